// [hw/dopc_regs.svh]
`ifndef DOPC_REGS_SVH
`define DOPC_REGS_SVH
// Frame type codes carried on the transmit request
`define DOPC_FRM_NONE 3'h0
`define DOPC_FRM_REG 3'h1
`define DOPC_FRM_PIO_SETUP 3'h2
`define DOPC_FRM_ACTIVATE 3'h3
`define DOPC_FRM_DATA 3'h4
// Packet protocol codes from the command decoder
`define DOPC_PROTO_NONDATA 3'h0
`define DOPC_PROTO_PIO_IN 3'h1
`define DOPC_PROTO_PIO_OUT 3'h2
`define DOPC_PROTO_DMA_IN 3'h3
`define DOPC_PROTO_DMA_OUT 3'h4
// Status bit positions in the eight-bit status byte
`define DOPC_STS_BSY 7
`define DOPC_STS_DRQ 3
`define DOPC_STS_ERR 0
// Status byte values
`define DOPC_STS_READY 8'h40
`define DOPC_STS_BUSY 8'h80
`define DOPC_STS_DRQ_ON 8'h08
`define DOPC_STS_ERR_ON 8'h01
`endif

// [hw/dopc_pkg.sv]
package dopc_pkg;
  typedef enum logic [4:0] {
    DOPC_IDLE,
    DOPC_DMA_WAIT,
    DOPC_DMA_ACTIVATE,
    DOPC_DMA_RECEIVE,
    DOPC_STATUS,
    DOPC_PKT_SETUP,
    DOPC_PKT_RECEIVE,
    DOPC_PKT_DECODE,
    DOPC_PKT_NONDATA,
    DOPC_PROGRAMMED_READ,
    DOPC_READ_SETUP,
    DOPC_BLOCK_SEND,
    DOPC_PROGRAMMED_WRITE,
    DOPC_WRITE_SETUP,
    DOPC_WRITE_RECEIVE,
    DOPC_PKT_DMA_IN,
    DOPC_PKT_DMA_OUT,
    DOPC_RELEASE
  } dopc_state_e;
  typedef logic [2:0] dopc_frame_t;
endpackage : dopc_pkg

// [hw/dopc_fsm.sv]
`include "dopc_regs.svh"

// Function
// RULE1 - One interrupt per DMA write, only after all data moved successfully; the code also pulses it after an aborted write's status frame
// RULE2 - DMA write command or more data needed enters the write-data wait
// RULE3 - From write-data wait go to activate when ready for a frame
// RULE4 - From write-data wait go to status when done or aborted
// RULE5 - Send DMA activate frame, then move to frame receive
// RULE6 - Take the data frame, then return to write-data wait
// RULE7 - Status report sends register frame with ending status, interrupt set
// RULE8 - After the status frame is sent, return to idle
// RULE9 - Release states exist only when queuing is built in
// RULE10 - Packet command sends PIO setup, then moves to packet receive
// RULE11 - Accept the packet data frame, then move to packet decode
// RULE12 - Decode picks one of five branches; non-data runs then reports status
// RULE13 - Programmed read: block ready goes to setup; done or error to status
// RULE14 - Read setup sends PIO setup frame, then goes to block send
// RULE15 - Block send sends data frame, then returns to programmed read
// RULE16 - Queuing device with block not ready goes to release
// RULE17 - Programmed write: ready to setup; all blocks or error to status
// RULE18 - Packet setup shows BSY0 DRQ1, I zero, ends BSY1 DRQ0, byte count
// RULE19 - Host sends one data frame per activation, never unsolicited
// RULE20 - Failed frame transfer is an aborting error leading to status
module dopc_fsm #(
  parameter bit QUEUING = 1'b0
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic dma_write_cmd_in,
  input wire logic packet_cmd_in,
  input wire logic [15:0] byte_count_in,
  input wire logic data_ready_in,
  input wire logic data_not_ready_in,
  input wire logic all_done_in,
  input wire logic cmd_error_in,
  input wire logic [2:0] packet_proto_in,
  input wire logic exec_done_in,
  input wire logic tx_done_in,
  input wire logic tx_fail_in,
  input wire logic rx_done_in,
  input wire logic rx_fail_in,
  output logic tx_req_out,
  output logic [2:0] tx_type_out,
  output logic tx_irq_out,
  output logic [7:0] tx_start_status_out,
  output logic [7:0] tx_end_status_out,
  output logic [15:0] tx_byte_count_out,
  output logic rx_expect_out,
  output logic irq_event_out,
  output logic busy_out,
  output logic [4:0] state_out
);
  dopc_pkg::dopc_state_e state_q, state_d;
  logic err_q, err_d;
  logic first_q, first_d;
  logic irq_q;

  // Frame request decoded from the state
  function automatic dopc_pkg::dopc_frame_t frame_of(input dopc_pkg::dopc_state_e s);
    case (s)
      dopc_pkg::DOPC_DMA_ACTIVATE: frame_of = `DOPC_FRM_ACTIVATE;
      dopc_pkg::DOPC_STATUS: frame_of = `DOPC_FRM_REG;
      dopc_pkg::DOPC_RELEASE: frame_of = `DOPC_FRM_REG;
      dopc_pkg::DOPC_PKT_SETUP: frame_of = `DOPC_FRM_PIO_SETUP;
      dopc_pkg::DOPC_READ_SETUP: frame_of = `DOPC_FRM_PIO_SETUP;
      dopc_pkg::DOPC_WRITE_SETUP: frame_of = `DOPC_FRM_PIO_SETUP;
      dopc_pkg::DOPC_BLOCK_SEND: frame_of = `DOPC_FRM_DATA;
      default: frame_of = `DOPC_FRM_NONE;
    endcase
  endfunction : frame_of

  // Receive expected in these states
  function automatic logic rx_of(input dopc_pkg::dopc_state_e s);
    rx_of = (s == dopc_pkg::DOPC_DMA_RECEIVE) || (s == dopc_pkg::DOPC_PKT_RECEIVE)
         || (s == dopc_pkg::DOPC_WRITE_RECEIVE);
  endfunction : rx_of

  wire tx_fault = tx_fail_in;
  wire rx_fault = rx_fail_in;
  // Release only reachable when queuing is built in
  // RULE9 queuing gate
  wire may_release = QUEUING && data_not_ready_in;
  wire abort_now = cmd_error_in || err_q;
  wire dopc_pkg::dopc_frame_t frame_d = frame_of(state_d);
  wire setup_d = (frame_d == `DOPC_FRM_PIO_SETUP);
  wire status_d = (state_d == dopc_pkg::DOPC_STATUS);
  wire release_d = (state_d == dopc_pkg::DOPC_RELEASE);
  wire status_sent = (state_q == dopc_pkg::DOPC_STATUS) && tx_done_in;

  // Next state logic
  always_comb begin
    state_d = state_q;
    // Aborting errors latch until the command ends
    err_d = err_q || cmd_error_in;
    first_d = first_q;
    case (state_q)
      dopc_pkg::DOPC_IDLE: begin
        err_d = 1'b0;
        first_d = 1'b1;
        // RULE2 DMA entry
        if (dma_write_cmd_in) begin
          state_d = dopc_pkg::DOPC_DMA_WAIT;
        // RULE10 packet entry
        end else if (packet_cmd_in) begin
          state_d = dopc_pkg::DOPC_PKT_SETUP;
        end
      end
      dopc_pkg::DOPC_DMA_WAIT: begin
        // RULE4 done or abort
        if (all_done_in || abort_now) begin
          state_d = dopc_pkg::DOPC_STATUS;
        // RULE3 ready to activate
        end else if (data_ready_in) begin
          state_d = dopc_pkg::DOPC_DMA_ACTIVATE;
        end
      end
      dopc_pkg::DOPC_DMA_ACTIVATE: begin
        // RULE5 activate sent
        // RULE20 transmit failure aborts
        if (tx_fault) begin
          err_d = 1'b1;
          state_d = dopc_pkg::DOPC_STATUS;
        end else if (tx_done_in) begin
          state_d = dopc_pkg::DOPC_DMA_RECEIVE;
        end
      end
      dopc_pkg::DOPC_DMA_RECEIVE: begin
        // RULE6 data taken
        // RULE19 one frame per activation
        if (rx_fault) begin
          err_d = 1'b1;
          state_d = dopc_pkg::DOPC_STATUS;
        end else if (rx_done_in) begin
          state_d = dopc_pkg::DOPC_DMA_WAIT;
        end
      end
      dopc_pkg::DOPC_PKT_SETUP: begin
        if (tx_fault) begin
          err_d = 1'b1;
          state_d = dopc_pkg::DOPC_STATUS;
        end else if (tx_done_in) begin
          state_d = dopc_pkg::DOPC_PKT_RECEIVE;
        end
      end
      dopc_pkg::DOPC_PKT_RECEIVE: begin
        // RULE11 packet received
        if (rx_fault) begin
          err_d = 1'b1;
          state_d = dopc_pkg::DOPC_STATUS;
        end else if (rx_done_in) begin
          state_d = dopc_pkg::DOPC_PKT_DECODE;
        end
      end
      dopc_pkg::DOPC_PKT_DECODE: begin
        first_d = 1'b1;
        // RULE12 protocol dispatch
        case (packet_proto_in)
          `DOPC_PROTO_NONDATA: state_d = dopc_pkg::DOPC_PKT_NONDATA;
          `DOPC_PROTO_PIO_IN: state_d = dopc_pkg::DOPC_PROGRAMMED_READ;
          `DOPC_PROTO_PIO_OUT: state_d = dopc_pkg::DOPC_PROGRAMMED_WRITE;
          `DOPC_PROTO_DMA_IN: state_d = dopc_pkg::DOPC_PKT_DMA_IN;
          `DOPC_PROTO_DMA_OUT: state_d = dopc_pkg::DOPC_PKT_DMA_OUT;
          default: begin
            err_d = 1'b1;
            state_d = dopc_pkg::DOPC_STATUS;
          end
        endcase
      end
      dopc_pkg::DOPC_PKT_NONDATA: begin
        if (exec_done_in || abort_now) begin
          // Any latched error rides on the status frame
          state_d = dopc_pkg::DOPC_STATUS;
        end
      end
      dopc_pkg::DOPC_PROGRAMMED_READ: begin
        // RULE13 read branch choice
        if (all_done_in || abort_now) begin
          state_d = dopc_pkg::DOPC_STATUS;
        end else if (data_ready_in) begin
          state_d = dopc_pkg::DOPC_READ_SETUP;
        // RULE16 release when not ready
        end else if (may_release) begin
          state_d = dopc_pkg::DOPC_RELEASE;
        end
      end
      dopc_pkg::DOPC_READ_SETUP: begin
        // RULE14 setup then send
        if (tx_fault) begin
          err_d = 1'b1;
          state_d = dopc_pkg::DOPC_STATUS;
        end else if (tx_done_in) begin
          first_d = 1'b0;
          state_d = dopc_pkg::DOPC_BLOCK_SEND;
        end
      end
      dopc_pkg::DOPC_BLOCK_SEND: begin
        // RULE15 block sent
        if (tx_fault) begin
          err_d = 1'b1;
          state_d = dopc_pkg::DOPC_STATUS;
        end else if (tx_done_in) begin
          state_d = dopc_pkg::DOPC_PROGRAMMED_READ;
        end
      end
      dopc_pkg::DOPC_PROGRAMMED_WRITE: begin
        // RULE17 write branch choice
        if (all_done_in || abort_now) begin
          state_d = dopc_pkg::DOPC_STATUS;
        end else if (data_ready_in) begin
          state_d = dopc_pkg::DOPC_WRITE_SETUP;
        end else if (may_release) begin
          state_d = dopc_pkg::DOPC_RELEASE;
        end
      end
      dopc_pkg::DOPC_WRITE_SETUP: begin
        if (tx_fault) begin
          err_d = 1'b1;
          state_d = dopc_pkg::DOPC_STATUS;
        end else if (tx_done_in) begin
          first_d = 1'b0;
          state_d = dopc_pkg::DOPC_WRITE_RECEIVE;
        end
      end
      dopc_pkg::DOPC_WRITE_RECEIVE: begin
        if (rx_fault) begin
          err_d = 1'b1;
          state_d = dopc_pkg::DOPC_STATUS;
        end else if (rx_done_in) begin
          state_d = dopc_pkg::DOPC_PROGRAMMED_WRITE;
        end
      end
      dopc_pkg::DOPC_PKT_DMA_IN, dopc_pkg::DOPC_PKT_DMA_OUT: begin
        // Loop bodies live elsewhere; finish on done or error
        if (all_done_in || abort_now) begin
          state_d = dopc_pkg::DOPC_STATUS;
        end
      end
      dopc_pkg::DOPC_STATUS, dopc_pkg::DOPC_RELEASE: begin
        // RULE8 back to idle
        if (tx_done_in || tx_fault) begin
          state_d = dopc_pkg::DOPC_IDLE;
        end
      end
      default: state_d = dopc_pkg::DOPC_IDLE;
    endcase
  end

  // State and flags
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= dopc_pkg::DOPC_IDLE;
      err_q <= 1'b0;
      first_q <= 1'b1;
    end else begin
      state_q <= state_d;
      err_q <= err_d;
      first_q <= first_d;
    end
  end

  // Registered transport request, presented with the state it belongs to
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_req_out <= 1'b0;
      tx_type_out <= `DOPC_FRM_NONE;
      tx_irq_out <= 1'b0;
      tx_start_status_out <= `DOPC_STS_READY;
      tx_end_status_out <= `DOPC_STS_READY;
      tx_byte_count_out <= 16'h0000;
      rx_expect_out <= 1'b0;
    end else begin
      tx_req_out <= (frame_d != `DOPC_FRM_NONE);
      tx_type_out <= frame_d;
      // RULE7 status frame interrupt bit
      // RULE18 packet setup bits
      tx_irq_out <= status_d || release_d || (setup_d && !first_d);
      tx_start_status_out <= setup_d ? `DOPC_STS_DRQ_ON
                           : (err_d ? (`DOPC_STS_READY | `DOPC_STS_ERR_ON) : `DOPC_STS_READY);
      tx_end_status_out <= setup_d ? `DOPC_STS_BUSY
                         : (err_d ? (`DOPC_STS_READY | `DOPC_STS_ERR_ON) : `DOPC_STS_READY);
      tx_byte_count_out <= setup_d ? byte_count_in : 16'h0000;
      rx_expect_out <= rx_of(state_d);
    end
  end

  // RULE1 single interrupt on completion
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_q <= 1'b0;
      irq_event_out <= 1'b0;
      busy_out <= 1'b0;
      state_out <= 5'h00;
    end else begin
      // Remembers the last status hand-off so a pulse never repeats
      irq_q <= status_sent;
      irq_event_out <= status_sent && !irq_q;
      busy_out <= (state_d != dopc_pkg::DOPC_IDLE);
      state_out <= state_d;
    end
  end
endmodule : dopc_fsm

// [bench/dopc_host_model.sv]
module dopc_host_model (
  input wire logic clk_in,
  input wire logic tx_req_in,
  input wire logic rx_expect_in,
  input wire logic [3:0] delay_in,
  input wire logic fail_in,
  output logic tx_done_out = 1'b0,
  output logic tx_fail_out = 1'b0,
  output logic rx_done_out = 1'b0,
  output logic rx_fail_out = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q = 4'h0;
  logic ans_q = 1'b0;
  // Answers one request after delay_in cycles, then rests a cycle
  always @(posedge clk_in) begin
    tx_done_out <= 1'b0;
    tx_fail_out <= 1'b0;
    rx_done_out <= 1'b0;
    rx_fail_out <= 1'b0;
    if (ans_q || !(tx_req_in || rx_expect_in)) begin
      ans_q <= 1'b0;
      wait_q <= 4'h0;
    end else if (wait_q < delay_in) begin
      wait_q <= wait_q + 4'h1;
    end else begin
      ans_q <= 1'b1;
      tx_done_out <= tx_req_in && !fail_in;
      tx_fail_out <= tx_req_in && fail_in;
      rx_done_out <= rx_expect_in && !tx_req_in && !fail_in;
      rx_fail_out <= rx_expect_in && !tx_req_in && fail_in;
    end
  end
endmodule : dopc_host_model

// [bench/dopc_fsm_props.sv]
`include "dopc_regs.svh"
module dopc_fsm_props #(
  parameter bit QUEUING = 1'b0
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic dma_write_cmd_in,
  input wire logic data_ready_in,
  input wire logic all_done_in,
  input wire logic cmd_error_in,
  input wire logic [15:0] byte_count_in,
  input wire logic tx_done_in,
  input wire logic tx_fail_in,
  input wire logic rx_done_in,
  input logic tx_req_out,
  input logic [2:0] tx_type_out,
  input logic tx_irq_out,
  input logic [7:0] tx_start_status_out,
  input logic [7:0] tx_end_status_out,
  input logic [15:0] tx_byte_count_out,
  input logic rx_expect_out,
  input logic irq_event_out,
  input logic [4:0] state_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // Steps of the write-data loop and the status hand-off
  sequence act_sent; state_out == 5'd2 && tx_done_in; endsequence
  sequence in_recv; state_out == 5'd3 && rx_expect_out; endsequence
  sequence stat_sent; state_out == 5'd4 && tx_done_in; endsequence
  sequence back_idle; state_out == 5'd0 && irq_event_out; endsequence
  cmd_to_wait_a: assert property (state_out == 5'd0 && dma_write_cmd_in |=> state_out == 5'd1)
    else $error("write command did not enter wait");
  wait_to_act_a: assert property (state_out == 5'd1 && data_ready_in && !all_done_in &&
    !cmd_error_in |=> state_out == 5'd2 && tx_req_out && tx_type_out == `DOPC_FRM_ACTIVATE)
    else $error("ready wait did not request activation");
  act_to_recv_a: assert property (act_sent |=> in_recv)
    else $error("sent activation did not start receive");
  recv_to_wait_a: assert property (state_out == 5'd3 && rx_done_in |=> state_out == 5'd1)
    else $error("received frame did not return to wait");
  status_frame_a: assert property (state_out == 5'd4 |-> tx_req_out &&
    tx_type_out == `DOPC_FRM_REG && tx_irq_out)
    else $error("status frame fields wrong");
  status_idle_a: assert property (stat_sent |=> back_idle)
    else $error("sent status did not return to idle");
  irq_after_status_a: assert property (irq_event_out |-> $past(state_out) == 5'd4)
    else $error("interrupt outside status");
  pkt_setup_a: assert property (state_out == 5'd5 |-> tx_type_out == `DOPC_FRM_PIO_SETUP &&
    !tx_irq_out && tx_start_status_out == `DOPC_STS_DRQ_ON &&
    tx_end_status_out == `DOPC_STS_BUSY && tx_byte_count_out == byte_count_in)
    else $error("packet setup frame fields wrong");
  no_release_a: assert property (QUEUING || state_out != 5'd17)
    else $error("release state without queuing");
  fail_abort_a: assert property (state_out == 5'd2 && tx_fail_in |=> state_out == 5'd4)
    else $error("failed activation did not abort");
endmodule : dopc_fsm_props
bind dopc_fsm dopc_fsm_props #(.QUEUING(QUEUING)) i_props (.clk_in, .resetn_in,
  .dma_write_cmd_in, .data_ready_in, .all_done_in, .cmd_error_in, .byte_count_in, .tx_done_in,
  .tx_fail_in, .rx_done_in, .tx_req_out, .tx_type_out, .tx_irq_out, .tx_start_status_out,
  .tx_end_status_out, .tx_byte_count_out, .rx_expect_out, .irq_event_out, .state_out);

// [bench/dma_out_packet_command_fsm_test.sv]
`include "dopc_regs.svh"
module dma_out_packet_command_fsm_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic dma_cmd = 1'b0, pkt_cmd = 1'b0, rdy = 1'b0, done = 1'b0, exec = 1'b0, fail = 1'b0;
  logic err = 1'b0, nrdy = 1'b0;
  logic [2:0] proto = 3'h0;
  logic [15:0] bcount = 16'h0200;
  logic [3:0] delay = 4'h0;
  logic tx_done, tx_fail, rx_done, rx_fail, tx_req, tx_irq, rx_expect, irq_ev, busy;
  logic [2:0] tx_type;
  logic [7:0] st_start, st_end;
  logic [15:0] tx_count;
  logic [4:0] state;
  logic [4:0] branch [6] = '{5'd8, 5'd9, 5'd12, 5'd15, 5'd16, 5'd4};
  int mismatches = 0, check_count = 0, cycles = 0, irqs = 0;
  always #10 clk_in = ~clk_in;
  dopc_fsm i_dut (.clk_in, .resetn_in, .dma_write_cmd_in(dma_cmd), .packet_cmd_in(pkt_cmd),
    .byte_count_in(bcount), .data_ready_in(rdy), .data_not_ready_in(nrdy), .all_done_in(done),
    .cmd_error_in(err), .packet_proto_in(proto), .exec_done_in(exec), .tx_done_in(tx_done),
    .tx_fail_in(tx_fail), .rx_done_in(rx_done), .rx_fail_in(rx_fail), .tx_req_out(tx_req),
    .tx_type_out(tx_type), .tx_irq_out(tx_irq), .tx_start_status_out(st_start),
    .tx_end_status_out(st_end), .tx_byte_count_out(tx_count), .rx_expect_out(rx_expect),
    .irq_event_out(irq_ev), .busy_out(busy), .state_out(state));
  dopc_host_model i_host (.clk_in, .tx_req_in(tx_req), .rx_expect_in(rx_expect),
    .delay_in(delay), .fail_in(fail), .tx_done_out(tx_done), .tx_fail_out(tx_fail),
    .rx_done_out(rx_done), .rx_fail_out(rx_fail));
  // Interrupt pulse counter and hang guard
  always @(posedge clk_in) begin
    if (irq_ev === 1'b1) irqs++;
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic step();
    @(posedge clk_in);
    #2;
  endtask : step
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_frame(input logic [2:0] typ, input logic irq);
    chk_val({11'h0, tx_req, tx_irq, tx_type}, {11'h0, 1'b1, irq, typ});
  endtask : chk_frame
  task automatic await(input logic [4:0] s);
    int n;
    n = 0;
    while (state !== s && n < 60) begin
      step();
      n++;
    end
    chk_val(16'(state), 16'(s));
  endtask : await
  task automatic start(input logic pkt);
    dma_cmd = !pkt;
    pkt_cmd = pkt;
    step();
    dma_cmd = 1'b0;
    pkt_cmd = 1'b0;
  endtask : start
  task automatic test_dma();
    int base;
    base = irqs;
    delay = 4'h3;
    start(1'b0);
    await(5'd1);
    rdy = 1'b1;
    repeat (2) begin
      await(5'd2);
      chk_frame(`DOPC_FRM_ACTIVATE, 1'b0);
      await(5'd3);
      await(5'd1);
    end
    rdy = 1'b0;
    done = 1'b1;
    await(5'd4);
    chk_val(16'(irqs - base), 16'h0);
    chk_frame(`DOPC_FRM_REG, 1'b1);
    chk_val(16'(st_start), 16'(`DOPC_STS_READY));
    chk_val(16'(st_end), 16'(`DOPC_STS_READY));
    chk_val(16'(busy), 16'h1);
    await(5'd0);
    step();
    chk_val(16'(irqs - base), 16'h1);
    chk_val(16'(busy), 16'h0);
    done = 1'b0;
    delay = 4'h0;
  endtask : test_dma
  task automatic test_abort(input logic via_fail);
    start(1'b0);
    await(5'd1);
    fail = via_fail;
    rdy = via_fail;
    err = !via_fail;
    await(5'd4);
    fail = 1'b0;
    rdy = 1'b0;
    err = 1'b0;
    chk_val(16'(st_start), 16'(`DOPC_STS_READY | `DOPC_STS_ERR_ON));
    chk_val(16'(st_end), 16'(`DOPC_STS_READY | `DOPC_STS_ERR_ON));
    await(5'd0);
  endtask : test_abort
  task automatic test_packet(input logic [2:0] p);
    proto = p;
    bcount = bcount + 16'h0100;
    start(1'b1);
    await(5'd5);
    chk_frame(`DOPC_FRM_PIO_SETUP, 1'b0);
    chk_val({st_start, st_end}, {`DOPC_STS_DRQ_ON, `DOPC_STS_BUSY});
    chk_val(tx_count, bcount);
    await(5'd6);
    await(5'd7);
    await(branch[p]);
    if (p == 3'h1 || p == 3'h2) begin
      nrdy = 1'b1;
      repeat (2) step();
      chk_val(16'(state), 16'(branch[p]));
      nrdy = 1'b0;
    end
    rdy = 1'b1;
    exec = 1'b1;
    if (p == 3'h1) begin
      await(5'd10);
      chk_frame(`DOPC_FRM_PIO_SETUP, 1'b0);
      await(5'd11);
      chk_val(16'(tx_type), 16'(`DOPC_FRM_DATA));
      await(5'd9);
    end
    if (p == 3'h2) begin
      await(5'd13);
      await(5'd14);
      await(5'd12);
    end
    rdy = 1'b0;
    done = 1'b1;
    await(5'd4);
    await(5'd0);
    done = 1'b0;
    exec = 1'b0;
  endtask : test_packet
  task automatic tally_and_finish();
    if (mismatches == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  // Reset, then each scenario in turn
  initial begin
    repeat (12) @(posedge clk_in);
    #2;
    chk_val({st_start, st_end}, 16'h4040);
    resetn_in = 1'b1;
    step();
    test_dma();
    test_abort(1'b0);
    test_abort(1'b1);
    for (int p = 0; p < 6; p++) test_packet(3'(p));
    tally_and_finish();
  end
endmodule : dma_out_packet_command_fsm_test
